// ==== hdl/uirc_defs.svh ====
`ifndef UIRC_DEFS_SVH
`define UIRC_DEFS_SVH
// Register offsets (byte addresses)
`define UIRC_DATA_OFS 8'h00
`define UIRC_IRQEN_OFS 8'h04
`define UIRC_FIFOCTL_OFS 8'h08
`define UIRC_LINEFMT_OFS 8'h0c
`define UIRC_MODEM_OFS 8'h10
`define UIRC_FIFOSTAT_OFS 8'h18
`define UIRC_IRQSTAT_OFS 8'h1c
`define UIRC_TIMEOUT_OFS 8'h20
`define UIRC_BAUD_OFS 8'h24
`define UIRC_FUNSEL_OFS 8'h30
// Field positions
`define UIRC_DIVX_EN_BIT 29
`define UIRC_DIVX_ONE_BIT 28
`define UIRC_DIVX_LSB 24
`define UIRC_DLY_LSB 8
`define UIRC_RTSLEV_LSB 16
`define UIRC_RXLEV_LSB 4
`define UIRC_AUTO_RTS_BIT 12
`define UIRC_AUTO_CTS_BIT 13
`define UIRC_RS485_AUTO_BIT 8
`define UIRC_RTS_SW_BIT 1
`define UIRC_FIFO_DEPTH 16
`define UIRC_OVS 5'h10
`define UIRC_IR_PULSE 5'h03
`define UIRC_MODEM_RST 32'h0000_0000
`endif

// ==== hdl/uirc_pkg.sv ====
package uirc_pkg;
    typedef enum logic [1:0] {FUN_UART, FUN_RS485, FUN_IRDA, FUN_RSV} uirc_fun_t;
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GAP} uirc_txst_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uirc_rxst_t;
    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [8:0] data;
    } uirc_rxent_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } uirc_bus_t;
endpackage

// ==== hdl/uirc_uart.sv ====
`timescale 1ns/100ps
`include "uirc_defs.svh"
// Notes on behaviour
// - Mode 0: baud tick every 16*(divisor+2) clocks.
// - Mode 1: tick every (extra+1)*(divisor+2) clocks; extra at least 8.
// - Mode 2: tick every divisor+2 clocks; divisor at least 8.
// - Sixteen-byte transmit FIFO before the shift register.
// - Sixteen-entry receive FIFO; each entry carries parity, framing, break flags.
// - Status readable anytime: six interrupt flags, transfer state, three errors.
// - Six interrupt sources: tx empty, rx level, line, timeout, modem, buffer error.
// - Line status interrupt from parity error, framing error or break.
// - In power-down any CTS change raises a wake-up event.
// - Three function modes: UART, infrared, RS-485, chosen by select field.
// - FIFO control and status identical in all modes.
// - Infrared pulses last 3/16 of a bit; decoder accepts them.
// - RS-485 mode carries nine-bit characters with address bit.
// - RS-485 direction on RTS, automatic or software level.
// - Programmable idle gap after last stop bit, eight-bit delay field.
// - Eight-bit receive timeout while data waits in FIFO.
// - Five to eight data bits.
// - One, one and a half or two stop bits.
// - Parity even, odd, none or stick.
// - Detect break, framing, parity, and rx or tx FIFO overflow.
// - CTS gates transmission; RTS drops at programmable rx level.
// - Rx-available flag when rx fill reaches trigger level.
// - Interrupt asserted while flag and enable set; software clears flag.
module uirc_uart
    import uirc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic rxPin,
    output logic txPin,
    input wire logic ctsPin,
    output logic rtsPin,
    input wire logic powerDown,
    output logic wakeUp,
    output logic irq
);
    localparam int D = `UIRC_FIFO_DEPTH;

    uirc_bus_t bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // Pin synchronisers reset to the idle high level so no false CTS change follows reset
    logic [1:0] rxSync_r, ctsSync_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxSync_r <= 2'h3;
            ctsSync_r <= 2'h3;
        end else begin
            rxSync_r <= {rxSync_r[0], rxPin};
            ctsSync_r <= {ctsSync_r[0], ctsPin};
        end
    end

    // Control registers
    logic [31:0] baud_r, lineFmt_r, fifoCtl_r, irqEn_r, timeout_r, modem_r;
    logic [1:0] funSel_r;
    wire logic wrData = bus.wr && bus.addr == `UIRC_DATA_OFS;
    wire logic rdData = bus.rd && bus.addr == `UIRC_DATA_OFS;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baud_r <= 32'h0;
            lineFmt_r <= 32'h3;
            fifoCtl_r <= 32'h0;
            irqEn_r <= 32'h0;
            timeout_r <= 32'h0;
            modem_r <= `UIRC_MODEM_RST;
            funSel_r <= 2'h0;
        end else if (bus.wr) begin
            unique case (bus.addr)
                `UIRC_BAUD_OFS: baud_r <= bus.wdata;
                `UIRC_LINEFMT_OFS: lineFmt_r <= bus.wdata;
                `UIRC_FIFOCTL_OFS: fifoCtl_r <= bus.wdata;
                `UIRC_IRQEN_OFS: irqEn_r <= bus.wdata;
                `UIRC_TIMEOUT_OFS: timeout_r <= bus.wdata;
                `UIRC_MODEM_OFS: modem_r <= bus.wdata;
                `UIRC_FUNSEL_OFS: funSel_r <= bus.wdata[1:0];
                default: ;
            endcase
        end
    end
    uirc_fun_t fun;
    assign fun = uirc_fun_t'(funSel_r);
    wire logic isIr = fun == FUN_IRDA;
    wire logic is485 = fun == FUN_RS485;

    // Baud generator: sixteen ticks per bit in every mode
    logic [20:0] baudAcc_r;
    logic tick;
    wire logic divXEn = baud_r[`UIRC_DIVX_EN_BIT];
    wire logic divXOne = baud_r[`UIRC_DIVX_ONE_BIT];
    wire logic [3:0] divX = baud_r[`UIRC_DIVX_LSB +: 4];
    wire logic [20:0] aPlus2 = 21'(baud_r[15:0]) + 21'h2;
    wire logic [20:0] bPlus1 = 21'(divX) + 21'h1;
    wire logic [20:0] bitClks = !divXEn ? {aPlus2[16:0], 4'h0} : divXOne ? aPlus2 : bPlus1 * aPlus2;
    // Adding 16 a clock and removing one bit time per tick spreads exactly 16 ticks
    // over each bit, so no divisor has to be a multiple of 16. Under 16 clocks a bit
    // (mode 2, divisor below 14) a tick comes every clock and the bit is stretched.
    wire logic [20:0] accSum = baudAcc_r + 21'h10;
    assign tick = accSum >= bitClks;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) baudAcc_r <= 21'h0;
        else if (!tick) baudAcc_r <= accSum;
        else baudAcc_r <= (bitClks < 21'h10) ? 21'h0 : accSum - bitClks;
    end

    // Transmit FIFO
    logic [7:0] txMem [D];
    logic [8:0] txAddr9_r [D];
    logic [3:0] txWp_r, txRp_r;
    logic [4:0] txCnt_r;
    logic txPop;
    wire logic txPush = wrData && txCnt_r != 5'(D);
    always_ff @(posedge clk) begin
        if (txPush) begin
            txMem[txWp_r] <= bus.wdata[7:0];
            txAddr9_r[txWp_r] <= bus.wdata[8:0];
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txWp_r <= 4'h0;
            txRp_r <= 4'h0;
            txCnt_r <= 5'h0;
        end else begin
            if (txPush) txWp_r <= txWp_r + 4'h1;
            if (txPop) txRp_r <= txRp_r + 4'h1;
            txCnt_r <= txCnt_r + 5'(txPush) - 5'(txPop);
        end
    end

    // Line format
    wire logic [3:0] nBits = is485 ? 4'h9 : 4'h5 + {2'h0, lineFmt_r[1:0]};
    wire logic parEn = lineFmt_r[3];
    wire logic parEven = lineFmt_r[4];
    wire logic parStick = lineFmt_r[5];
    // Stop length in samples: 16, 24 (1.5) or 32
    wire logic [5:0] stopLen = !lineFmt_r[2] ? 6'd16 : (lineFmt_r[1:0] == 2'h0 ? 6'd24 : 6'd32);
    function automatic logic parBit(input logic [8:0] d, input logic [3:0] n);
        logic p;
        p = 1'b0;
        for (int i = 0; i < 9; i++)
            if (4'(i) < n) p ^= d[i];
        if (parStick) parBit = !parEven;
        else parBit = parEven ? p : !p;
    endfunction

    // Transmitter, 16 samples per bit
    uirc_txst_t txSt_r;
    logic [8:0] txSh_r;
    logic [3:0] txBit_r;
    logic [5:0] txSmp_r;
    logic [7:0] gapCnt_r;
    logic txLine_r, txPar_r;
    wire logic ctsOk = !irqEn_r[`UIRC_AUTO_CTS_BIT] || ctsSync_r[1];
    wire logic [5:0] bitEnd = (txSt_r == TX_STOP) ? stopLen - 6'h1 : 6'd15;
    wire logic sTick = tick;
    // Starting on a tick keeps the start bit exactly one bit long
    assign txPop = txSt_r == TX_IDLE && txCnt_r != 5'h0 && ctsOk && sTick;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txSt_r <= TX_IDLE;
            txSh_r <= 9'h0;
            txBit_r <= 4'h0;
            txSmp_r <= 6'h0;
            gapCnt_r <= 8'h0;
            txLine_r <= 1'b1;
            txPar_r <= 1'b0;
        end else begin
            unique case (txSt_r)
                TX_IDLE: begin
                    txLine_r <= 1'b1;
                    if (txPop) begin
                        txSh_r <= is485 ? txAddr9_r[txRp_r] : {1'b0, txMem[txRp_r]};
                        txPar_r <= parBit(is485 ? txAddr9_r[txRp_r] : {1'b0, txMem[txRp_r]}, nBits);
                        txSt_r <= TX_START;
                        txSmp_r <= 6'h0;
                    end
                end
                TX_GAP: begin
                    txLine_r <= 1'b1;
                    if (sTick && txSmp_r == 6'd15) begin
                        txSmp_r <= 6'h0;
                        if (gapCnt_r == 8'h0) txSt_r <= TX_IDLE;
                        else gapCnt_r <= gapCnt_r - 8'h1;
                    end else if (sTick) txSmp_r <= txSmp_r + 6'h1;
                end
                default: begin
                    txLine_r <= txSt_r == TX_START ? 1'b0 : txSt_r == TX_DATA ? txSh_r[0] :
                                txSt_r == TX_PAR ? txPar_r : 1'b1;
                    if (sTick) begin
                        txSmp_r <= (txSmp_r == bitEnd) ? 6'h0 : txSmp_r + 6'h1;
                        if (txSmp_r == bitEnd) begin
                            unique case (txSt_r)
                                TX_START: begin txSt_r <= TX_DATA; txBit_r <= 4'h0; end
                                TX_DATA: begin
                                    txSh_r <= {1'b0, txSh_r[8:1]};
                                    txBit_r <= txBit_r + 4'h1;
                                    if (txBit_r == nBits - 4'h1) txSt_r <= parEn ? TX_PAR : TX_STOP;
                                end
                                TX_PAR: txSt_r <= TX_STOP;
                                default: begin
                                    txSt_r <= (timeout_r[`UIRC_DLY_LSB +: 8] == 8'h0) ? TX_IDLE : TX_GAP;
                                    gapCnt_r <= timeout_r[`UIRC_DLY_LSB +: 8] - 8'h1;
                                end
                            endcase
                        end
                    end
                end
            endcase
        end
    end
    // Infrared encoder: low pulse of 3 samples inside each zero bit
    wire logic txIdle = txSt_r == TX_IDLE || txSt_r == TX_GAP;
    assign txPin = isIr ? !(!txLine_r && txSmp_r < 6'(`UIRC_IR_PULSE)) : txLine_r;

    // Receiver
    logic [1:0] irHold_r;
    wire logic rxIn = isIr ? !(irHold_r != 2'h0 || !rxSync_r[1]) : rxSync_r[1];
    // Stretches a 3/16 infrared pulse to cover the centre sample
    logic [4:0] irStretch_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irStretch_r <= 5'h0;
            irHold_r <= 2'h0;
        end else begin
            if (!rxSync_r[1]) irStretch_r <= 5'd16;
            else if (sTick && irStretch_r != 5'h0) irStretch_r <= irStretch_r - 5'h1;
            irHold_r <= {1'b0, irStretch_r != 5'h0};
        end
    end

    uirc_rxst_t rxSt_r;
    logic [8:0] rxSh_r;
    logic [3:0] rxBit_r, rxSmp_r;
    logic rxPar_r, rxPrev_r, rxAllZero_r;
    logic rxPush;
    uirc_rxent_t rxEnt;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxSt_r <= RX_IDLE;
            rxSh_r <= 9'h0;
            rxBit_r <= 4'h0;
            rxSmp_r <= 4'h0;
            rxPar_r <= 1'b0;
            rxPrev_r <= 1'b1;
            rxAllZero_r <= 1'b0;
        end else begin
            rxPrev_r <= rxIn;
            if (rxSt_r == RX_IDLE) begin
                if (rxPrev_r && !rxIn) begin
                    rxSt_r <= RX_START;
                    rxSmp_r <= 4'h0;
                    rxAllZero_r <= 1'b1;
                    rxSh_r <= 9'h0;
                end
            end else if (sTick) begin
                rxSmp_r <= rxSmp_r + 4'h1;
                if (rxSmp_r == 4'd7) begin
                    if (rxIn) rxAllZero_r <= 1'b0;
                    unique case (rxSt_r)
                        RX_START: begin
                            rxSt_r <= rxIn ? RX_IDLE : RX_DATA;
                            rxBit_r <= 4'h0;
                        end
                        RX_DATA: begin
                            rxSh_r[rxBit_r] <= rxIn;
                            rxBit_r <= rxBit_r + 4'h1;
                            if (rxBit_r == nBits - 4'h1) rxSt_r <= parEn ? RX_PAR : RX_STOP;
                        end
                        RX_PAR: begin
                            rxPar_r <= rxIn;
                            rxSt_r <= RX_STOP;
                        end
                        default: rxSt_r <= RX_IDLE;
                    endcase
                end
            end
        end
    end
    assign rxPush = rxSt_r == RX_STOP && sTick && rxSmp_r == 4'd7;
    assign rxEnt = '{brk: rxAllZero_r && !rxIn, fe: !rxIn,
                     pe: parEn && rxPar_r != parBit(rxSh_r, nBits), data: rxSh_r};

    // Receive FIFO with per-entry flags
    uirc_rxent_t rxMem [D];
    logic [3:0] rxWp_r, rxRp_r;
    logic [4:0] rxCnt_r;
    wire logic rxFull = rxCnt_r == 5'(D);
    wire logic rxPop = rdData && rxCnt_r != 5'h0;
    wire logic rxWr = rxPush && !rxFull;
    always_ff @(posedge clk) begin
        if (rxWr) rxMem[rxWp_r] <= rxEnt;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxWp_r <= 4'h0;
            rxRp_r <= 4'h0;
            rxCnt_r <= 5'h0;
        end else begin
            if (rxWr) rxWp_r <= rxWp_r + 4'h1;
            if (rxPop) rxRp_r <= rxRp_r + 4'h1;
            rxCnt_r <= rxCnt_r + 5'(rxWr) - 5'(rxPop);
        end
    end

    // Receive time-out, counted in bit times
    logic [7:0] toCnt_r;
    logic [3:0] toSmp_r;
    logic toFlag;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            toCnt_r <= 8'h0;
            toSmp_r <= 4'h0;
        end else if (rxCnt_r == 5'h0 || rxPush || rxPop) begin
            toCnt_r <= 8'h0;
            toSmp_r <= 4'h0;
        end else if (sTick && !toFlag) begin
            toSmp_r <= toSmp_r + 4'h1;
            if (toSmp_r == 4'd15) toCnt_r <= toCnt_r + 8'h1;
        end
    end
    assign toFlag = rxCnt_r != 5'h0 && toCnt_r >= timeout_r[7:0] && timeout_r[7:0] != 8'h0;

    // Sticky flags: set beats a write-one clear
    logic pe_r, fe_r, brk_r, txOv_r, rxOv_r, dcts_r, ctsPrev_r, wake_r;
    wire logic stClr = bus.wr && bus.addr == `UIRC_FIFOSTAT_OFS;
    wire logic msClr = bus.wr && bus.addr == `UIRC_MODEM_OFS;
    wire logic ctsChg = ctsSync_r[1] != ctsPrev_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {pe_r, fe_r, brk_r, txOv_r, rxOv_r, dcts_r, wake_r} <= 7'h0;
            ctsPrev_r <= 1'b1;
        end else begin
            ctsPrev_r <= ctsSync_r[1];
            pe_r <= (rxWr && rxEnt.pe) || (pe_r && !(stClr && bus.wdata[4]));
            fe_r <= (rxWr && rxEnt.fe) || (fe_r && !(stClr && bus.wdata[5]));
            brk_r <= (rxWr && rxEnt.brk) || (brk_r && !(stClr && bus.wdata[6]));
            rxOv_r <= (rxPush && rxFull) || (rxOv_r && !(stClr && bus.wdata[0]));
            txOv_r <= (wrData && !txPush) || (txOv_r && !(stClr && bus.wdata[24]));
            dcts_r <= ctsChg || (dcts_r && !(msClr && bus.wdata[0]));
            wake_r <= (ctsChg && powerDown) || (wake_r && !(msClr && bus.wdata[0]));
        end
    end
    assign wakeUp = ctsChg && powerDown;

    // Interrupt flags: rx level, tx empty, line, modem, timeout, buffer error
    wire logic [3:0] rxLev = fifoCtl_r[`UIRC_RXLEV_LSB +: 4];
    wire logic [5:0] flags = {rxOv_r || txOv_r, toFlag, dcts_r, pe_r || fe_r || brk_r,
                              txCnt_r == 5'h0, rxCnt_r != 5'h0 && rxCnt_r >= {1'b0, rxLev} + 5'h1};
    assign irq = |(flags & irqEn_r[5:0]);

    // Flow control and RS-485 direction
    wire logic [3:0] rtsLev = fifoCtl_r[`UIRC_RTSLEV_LSB +: 4];
    wire logic rtsAuto = !(rxCnt_r >= {1'b0, rtsLev} + 5'h1);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rtsPin <= 1'b0;
        else if (is485) rtsPin <= modem_r[`UIRC_RS485_AUTO_BIT] ? !txIdle : modem_r[`UIRC_RTS_SW_BIT];
        else rtsPin <= irqEn_r[`UIRC_AUTO_RTS_BIT] ? rtsAuto : modem_r[`UIRC_RTS_SW_BIT];
    end

    // Read mux, data one cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rdata <= 32'h0;
        else if (bus.rd) begin
            unique case (bus.addr)
                `UIRC_DATA_OFS: rdata <= {23'h0, rxMem[rxRp_r].data};
                `UIRC_IRQEN_OFS: rdata <= irqEn_r;
                `UIRC_FIFOCTL_OFS: rdata <= fifoCtl_r;
                `UIRC_LINEFMT_OFS: rdata <= lineFmt_r;
                `UIRC_MODEM_OFS: rdata <= {modem_r[31:6], wake_r, ctsSync_r[1], 3'h0, dcts_r};
                `UIRC_FIFOSTAT_OFS: rdata <= {3'h0, txIdle && txCnt_r == 5'h0, 3'h0, txOv_r, txCnt_r == 5'(D),
                    txCnt_r == 5'h0, 2'h0, txCnt_r[3:0], rxFull, rxCnt_r == 5'h0, 2'h0,
                    rxCnt_r[3:0], 1'b0, brk_r, fe_r, pe_r, 3'h0, rxOv_r};
                `UIRC_IRQSTAT_OFS: rdata <= {18'h0, flags & irqEn_r[5:0], 2'h0, flags};
                `UIRC_TIMEOUT_OFS: rdata <= timeout_r;
                `UIRC_BAUD_OFS: rdata <= baud_r;
                `UIRC_FUNSEL_OFS: rdata <= {30'h0, funSel_r};
                default: rdata <= 32'h0;
            endcase
        end else rdata <= 32'h0;
    end
endmodule

// ==== dv/uirc_uart_chk.sv ====
`timescale 1ns/100ps
module uirc_uart_chk
    import uirc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic rxPin,
    input wire logic txPin,
    input wire logic ctsPin,
    input wire logic rtsPin,
    input wire logic powerDown,
    input wire logic wakeUp,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [5:0] ien_r;
    logic [31:0] baud_r;
    logic [1:0] fun_r;
    logic txUsed_r;
    logic [15:0] low_r;
    logic [15:0] bitLen;
    // Bit time from the divider equations, independent of how the design counts it
    assign bitLen = !baud_r[29] ? 16'(16 * (baud_r[15:0] + 2)) : baud_r[28] ? 16'(baud_r[15:0] + 2) :
        16'((baud_r[27:24] + 1) * (baud_r[15:0] + 2));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ien_r <= 6'h00;
            baud_r <= 32'h0;
            fun_r <= 2'h0;
            txUsed_r <= 1'b0;
        end else if (wr) begin
            if (addr == 8'h04) ien_r <= wdata[5:0];
            if (addr == 8'h24) baud_r <= wdata;
            if (addr == 8'h30) fun_r <= wdata[1:0];
            if (addr == 8'h00) txUsed_r <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) low_r <= 16'h0;
        else low_r <= txPin ? 16'h0 : low_r + 16'h1;
    end
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read cycle");
    AST_IRQ_MASK: assert property ($past(rd) && $past(addr) == 8'h1c |-> rdata[13:8] == (rdata[5:0] & $past(ien_r)))
        else $error("masked flags differ from raw and enable");
    AST_IRQ_OFF: assert property (ien_r == 6'h0 && $past(ien_r) == 6'h0 |-> !irq)
        else $error("irq without enable");
    AST_TX_QUIET: assert property (!txUsed_r |-> txPin)
        else $error("tx line left idle level without data");
    AST_WAKE_PD: assert property (wakeUp |-> powerDown)
        else $error("wake event outside power down");
    AST_WAKE_FIRES: assert property (powerDown && $changed(ctsPin) |-> ##[1:4] wakeUp)
        else $error("no wake event after cts change");
    AST_RTS_SW: assert property (wr && addr == 8'h10 && fun_r == 2'h1 && !wdata[8] |-> ##2 rtsPin == $past(wdata[1], 2))
        else $error("rts does not follow software level");
    // Low runs must be whole bits; wrong divider mode or off-by-one breaks this
    AST_BIT_GRID: assert property (txUsed_r && fun_r != 2'h2 && $rose(txPin) |-> low_r % bitLen == 16'h0)
        else $error("low run not a whole number of bits");
    cover property (wakeUp);
    cover property ($past(rd) && $past(addr) == 8'h1c && irq);
    cover property (txUsed_r && $rose(txPin));
endmodule
bind uirc_uart uirc_uart_chk chk(.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxPin(rxPin), .txPin(txPin), .ctsPin(ctsPin), .rtsPin(rtsPin), .powerDown(powerDown),
    .wakeUp(wakeUp), .irq(irq));

// ==== dv/uirc_remote.sv ====
`timescale 1ns/100ps
module uirc_remote #(parameter int BITCLK = 32) (
    input wire logic clk,
    input wire logic txPin,
    output logic rxPin,
    output logic ctsPin
);
    initial begin
        rxPin = 1'b1;
        ctsPin = 1'b1;
    end
    task automatic sendBit(input logic b);
        rxPin <= b;
        repeat (BITCLK) @(posedge clk);
    endtask
    // A low stop level lets the bench provoke a framing error
    task automatic sendFrame(input int n, input logic [7:0] v, input logic usePar, input logic par, input logic stp);
        sendBit(1'b0);
        for (int i = 0; i < n; i++) sendBit(v[i]);
        if (usePar) sendBit(par);
        sendBit(stp);
        rxPin <= 1'b1;
    endtask
    // Samples mid-bit, so edge timing slack of a cycle does not matter
    task automatic recvFrame(input int n, input logic usePar, output logic [7:0] v, output logic par,
        output logic stpOk);
        v = 8'h00;
        par = 1'b0;
        while (txPin !== 1'b0) @(posedge clk);
        repeat (BITCLK / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (BITCLK) @(posedge clk);
            v[i] = txPin;
        end
        if (usePar) begin
            repeat (BITCLK) @(posedge clk);
            par = txPin;
        end
        repeat (BITCLK) @(posedge clk);
        stpOk = txPin;
    endtask
endmodule

// ==== dv/test_uirc_uart.sv ====
`timescale 1ns/100ps
module test_uirc_uart;
    import uirc_pkg::*;
    logic clk, nrst, wr, rd, powerDown, rxPin, txPin, ctsPin, rtsPin, wakeUp, irq, wakeSeen;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    int n_errors = 0;
    int compares = 0;
    logic [7:0] q[$];
    logic [7:0] fmt[4] = '{8'h03, 8'h1a, 8'h2c, 8'h0d};
    logic [31:0] bd[3] = '{32'h0000_0000, 32'h2f00_0000, 32'h3000_001e};
    uirc_uart dut(.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rxPin(rxPin), .txPin(txPin), .ctsPin(ctsPin), .rtsPin(rtsPin), .powerDown(powerDown),
        .wakeUp(wakeUp), .irq(irq));
    uirc_remote #(.BITCLK(32)) rem(.clk(clk), .txPin(txPin), .rxPin(rxPin), .ctsPin(ctsPin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (wakeUp === 1'b1) wakeSeen <= 1'b1;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrReg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // Read data stand between the two edges; taken mid-cycle where they are settled
    task automatic rdReg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    function automatic logic exPar(input logic [7:0] f, input logic [7:0] v);
        if (f[5]) return ~f[4];
        return f[4] ? ^v : ~^v;
    endfunction
    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        test_done();
    end
    initial begin
        logic [7:0] v, g, m;
        logic p, s;
        int n, bad;
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        powerDown = 1'b0;
        wakeSeen = 1'b0;
        d = $urandom(32'h5d88e8dc);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk("txPin", 32'h1, {31'h0, txPin});
        rdReg(8'h0c);
        chk("line format", 32'h3, d);
        rdReg(8'h2c);
        chk("unmapped", 32'h0, d);
        rdReg(8'h1c);
        chk("raw flags", 32'h2, {26'h0, d[5:0]});
        for (int i = 0; i < 4; i++) begin
            n = 5 + fmt[i][1:0];
            m = 8'((1 << n) - 1);
            wrReg(8'h24, bd[i % 3]);
            wrReg(8'h0c, {24'h0, fmt[i]});
            v = 8'($urandom) & m;
            wrReg(8'h00, {24'h0, v});
            rem.recvFrame(n, fmt[i][3], g, p, s);
            chk("tx data", {24'h0, v}, {24'h0, g});
            if (fmt[i][3]) chk("tx parity", {31'h0, exPar(fmt[i], v)}, {31'h0, p});
            chk("tx stop", 32'h1, {31'h0, s});
            v = 8'($urandom) & m;
            rem.sendFrame(n, v, fmt[i][3], exPar(fmt[i], v), 1'b1);
            repeat (64) @(posedge clk);
            rdReg(8'h00);
            chk("rx data", {24'h0, v}, {24'h0, d[7:0] & m});
            rdReg(8'h18);
            chk("rx errors", 32'h0, {29'h0, d[6:4]});
        end
        wrReg(8'h24, 32'h0);
        wrReg(8'h0c, 32'h3);
        wrReg(8'h04, 32'h4);
        rem.sendFrame(8, 8'ha5, 1'b0, 1'b0, 1'b0);
        repeat (64) @(posedge clk);
        chk("line irq", 32'h1, {31'h0, irq});
        rdReg(8'h18);
        chk("frame error", 32'h1, {31'h0, d[5]});
        rdReg(8'h00);
        chk("rx data fe", 32'ha5, {24'h0, d[7:0]});
        wrReg(8'h18, 32'h70);
        chk("line irq clear", 32'h0, {31'h0, irq});
        wrReg(8'h08, 32'h30);
        for (int k = 0; k < 17; k++) begin
            v = 8'($urandom);
            q.push_back(v);
            rem.sendFrame(8, v, 1'b0, 1'b0, 1'b1);
            repeat (40) @(posedge clk);
            rdReg(8'h1c);
            chk("rx level flag", {31'h0, k >= 3}, {31'h0, d[0]});
        end
        rdReg(8'h18);
        chk("rx overflow", 32'h1, {31'h0, d[0]});
        rdReg(8'h1c);
        chk("buffer error", 32'h1, {31'h0, d[5]});
        for (int k = 0; k < 16; k++) begin
            rdReg(8'h00);
            chk("rx fifo", {24'h0, q.pop_front()}, {24'h0, d[7:0]});
        end
        q.delete();
        wrReg(8'h18, 32'h0100_0001);
        wrReg(8'h04, 32'h8);
        powerDown <= 1'b1;
        for (int f = 0; f < 3; f++) begin
            wrReg(8'h30, (f + 2) % 3);
            wrReg(8'h10, 32'h1);
            wakeSeen <= 1'b0;
            rem.ctsPin <= ~ctsPin;
            repeat (8) @(posedge clk);
            chk("wake", 32'h1, {31'h0, wakeSeen});
            chk("modem irq", 32'h1, {31'h0, irq});
        end
        wrReg(8'h10, 32'h2);
        @(posedge clk);
        chk("rts high", 32'h1, {31'h0, rtsPin});
        wrReg(8'h10, 32'h0);
        @(posedge clk);
        chk("rts low", 32'h0, {31'h0, rtsPin});
        powerDown <= 1'b0;
        wrReg(8'h30, 32'h0);
        wrReg(8'h10, 32'h1);
        wrReg(8'h04, 32'h2000);
        rem.ctsPin <= 1'b0;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 18; k++) begin
            v = 8'($urandom);
            q.push_back(v);
            wrReg(8'h00, {24'h0, v});
        end
        bad = 0;
        repeat (200) @(posedge clk) if (txPin !== 1'b1) bad++;
        chk("cts hold", 32'h0, bad);
        rdReg(8'h18);
        chk("tx overflow", 32'h1, {31'h0, d[24]});
        rem.ctsPin <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            rem.recvFrame(8, 1'b0, g, p, s);
            chk("tx fifo", {24'h0, q.pop_front()}, {24'h0, g});
        end
        test_done();
    end
endmodule
